/* dv/fpch_handler_properties.sv */
// Purpose: port checker of the command handler
// Assumes: single clock domain
// Notes: attached by bind
`timescale 1ns/100ps
`include "fpch_defines.vh"
module fpch_handler_properties (
   input wire sys_clk,
   input wire rst_n,
   input wire flash_mode_select_pin,
   input wire tool_serial_pin,
   input wire uart_mode,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire prog_mode_ff,
   input wire mode_pulldown_ff,
   input wire tx_valid_ff,
   input wire [7:0] tx_data_ff,
   input wire [7:0] baud_ff,
   input wire [7:0] security_ff,
   input wire busy_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_pulldown_off: assert property (prog_mode_ff |-> !mode_pulldown_ff)
      else $error("pulldown on in programming mode");
   a_mode_pins: assert property ($rose(prog_mode_ff) |-> $past(flash_mode_select_pin, 3)
      && $past(tool_serial_pin, 3)) else $error("mode entered without pins");
   a_mode_stays: assert property (prog_mode_ff |=> prog_mode_ff)
      else $error("programming mode lost");
   a_idle_quiet: assert property (!prog_mode_ff |-> !tx_valid_ff)
      else $error("answer outside programming mode");
   a_answer_code: assert property (tx_valid_ff && !$past(tx_valid_ff) |->
      tx_data_ff inside {`FPCH_ACK, `FPCH_NAK, `FPCH_BLANK_NG}) else $error("bad answer code");
   a_busy_answer: assert property ($rose(busy_ff) |-> ##[0:40] tx_valid_ff)
      else $error("busy without answer");
   a_baud_gate: assert property ($changed(baud_ff) |-> uart_mode && tx_valid_ff
      && tx_data_ff == `FPCH_ACK) else $error("baud changed wrongly");
   a_sec_sticky: assert property (1'b1 |=> ($past(security_ff) & ~security_ff) == 8'h00)
      else $error("security bit cleared");
   a_sec_ack: assert property ($changed(security_ff) |-> tx_valid_ff
      && tx_data_ff == `FPCH_ACK) else $error("security set without ack");
   c_busy: cover property ($rose(busy_ff));
   c_blank_ng: cover property (tx_valid_ff && tx_data_ff == `FPCH_BLANK_NG);
   c_baud: cover property ($changed(baud_ff));
endmodule // fpch_handler_properties
bind fpch_handler fpch_handler_properties fpch_handler_properties_inst (.sys_clk(sys_clk),
   .rst_n(rst_n), .flash_mode_select_pin(flash_mode_select_pin),
   .tool_serial_pin(tool_serial_pin), .uart_mode(uart_mode), .rx_valid(rx_valid),
   .rx_data(rx_data), .prog_mode_ff(prog_mode_ff), .mode_pulldown_ff(mode_pulldown_ff),
   .tx_valid_ff(tx_valid_ff), .tx_data_ff(tx_data_ff), .baud_ff(baud_ff),
   .security_ff(security_ff), .busy_ff(busy_ff));

/* dv/fpch_prog_model.sv */
// Purpose: external programmer model on the byte link
// Assumes: bytes leave on the falling edge of sys_clk
// Notes: the idle data line carries the inverse of the last byte
`timescale 1ns/100ps
module fpch_prog_model (
   input wire sys_clk,
   output reg flash_mode_select_pin,
   output reg tool_serial_pin,
   output reg rx_valid,
   output reg [7:0] rx_data
);
   initial begin
      flash_mode_select_pin = 1'b1;
      tool_serial_pin = 1'b1;
      rx_valid = 1'b0;
      rx_data = 8'hA5;
   end
   task send(input [7:0] b);
      begin
         @(negedge sys_clk);
         rx_valid = 1'b1;
         rx_data = b;
         @(negedge sys_clk);
         rx_valid = 1'b0;
         rx_data = ~b;
      end
   endtask
   task set_pins(input fm, input ts);
      begin
         @(negedge sys_clk);
         flash_mode_select_pin = fm;
         tool_serial_pin = ts;
      end
   endtask
endmodule // fpch_prog_model

/* dv/testbench.sv */
// Purpose: self-checking bench of the command handler
// Assumes: default parameters, 4 blocks of 4 bytes
// Notes: inputs change on the falling edge
`timescale 1ns/100ps
`include "fpch_defines.vh"
module testbench;
   reg sys_clk = 1'b0;
   reg rst_n = 1'b0;
   reg uart_mode = 1'b0;
   wire fms, tsp, rx_valid, prog_mode_ff, mode_pulldown_ff, tx_valid_ff, busy_ff;
   wire [7:0] rx_data, tx_data_ff, baud_ff, security_ff;
   integer errors = 0;
   integer total_checks = 0;
   integer cycles = 0;
   reg [7:0] d;
   initial forever #25 sys_clk = ~sys_clk;
   fpch_prog_model fpch_prog_model_inst (.sys_clk(sys_clk), .flash_mode_select_pin(fms),
      .tool_serial_pin(tsp), .rx_valid(rx_valid), .rx_data(rx_data));
   fpch_handler fpch_handler_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .flash_mode_select_pin(fms), .tool_serial_pin(tsp), .uart_mode(uart_mode),
      .rx_valid(rx_valid), .rx_data(rx_data), .prog_mode_ff(prog_mode_ff),
      .mode_pulldown_ff(mode_pulldown_ff), .tx_valid_ff(tx_valid_ff), .tx_data_ff(tx_data_ff),
      .baud_ff(baud_ff), .security_ff(security_ff), .busy_ff(busy_ff));
   task check(input [7:0] seen, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task get(output [7:0] b);
      integer n;
      begin
         n = 0;
         while (tx_valid_ff !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n = n + 1;
         end
         b = (n < 40) ? tx_data_ff : 8'hXX;
         @(negedge sys_clk);
      end
   endtask
   task run(input [47:0] v, input integer n);
      integer i;
      begin
         for (i = n - 1; i >= 0; i = i - 1) fpch_prog_model_inst.send(v[8*i +: 8]);
         get(d);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   task t_entry;
      begin
         repeat (4) @(negedge sys_clk);
         check({7'h00, mode_pulldown_ff}, 8'h01);
         rst_n = 1'b1;
         repeat (8) @(negedge sys_clk);
         check({7'h00, prog_mode_ff}, 8'h01);
         check({7'h00, mode_pulldown_ff}, 8'h00);
         $display("entry done");
      end
   endtask
   task t_answers;
      begin
         run(`FPCH_CMD_RESET, 1); check(d, `FPCH_ACK);
         run(8'h77, 1); check(d, `FPCH_NAK);
         run(`FPCH_CMD_SIGNATURE, 1); check(d, `FPCH_ACK);
         get(d); check(d, `FPCH_SIG_BYTE);
         run(`FPCH_CMD_VERSION, 1); check(d, `FPCH_ACK);
         get(d); check(d, `FPCH_VER_BYTE);
         run({`FPCH_CMD_BAUD_SET, 8'h3C}, 2); check(d, `FPCH_NAK);
         check(baud_ff, `FPCH_BAUD_RST);
         uart_mode = 1'b1;
         run({`FPCH_CMD_BAUD_SET, 8'h3C}, 2); check(d, `FPCH_ACK);
         check(baud_ff, 8'h3C);
         $display("answers done");
      end
   endtask
   task t_flash;
      begin
         run({`FPCH_CMD_PROGRAM, 8'h01, 32'h0FF0AA55}, 6); check(d, `FPCH_ACK);
         run({`FPCH_CMD_VERIFY, 8'h01, 32'h0FF0AA55}, 6); check(d, `FPCH_ACK);
         run({`FPCH_CMD_VERIFY, 8'h01, 32'h0FF0AA56}, 6); check(d, `FPCH_NAK);
         run({`FPCH_CMD_CHECKSUM, 8'h01}, 2); check(d, `FPCH_ACK);
         get(d); check(d, 8'hFE);
         run({`FPCH_CMD_BLANK_CHECK, 8'h01}, 2); check(d, `FPCH_BLANK_NG);
         run({`FPCH_CMD_BLANK_CHECK, 8'h02}, 2); check(d, `FPCH_ACK);
         run({`FPCH_CMD_PROGRAM, 8'h00, 32'h12345678}, 6); check(d, `FPCH_ACK);
         fpch_prog_model_inst.send(`FPCH_CMD_BLOCK_ERASE);
         fpch_prog_model_inst.send(8'h01);
         check({7'h00, busy_ff}, 8'h01);
         fpch_prog_model_inst.send(`FPCH_CMD_RESET);
         get(d); check(d, `FPCH_NAK);
         get(d); check(d, `FPCH_ACK);
         run({`FPCH_CMD_BLANK_CHECK, 8'h01}, 2); check(d, `FPCH_ACK);
         run({`FPCH_CMD_CHECKSUM, 8'h00}, 2); check(d, `FPCH_ACK);
         get(d); check(d, 8'h14);
         $display("flash done");
      end
   endtask
   task t_chip;
      begin
         run(`FPCH_CMD_CHIP_ERASE, 1); check(d, `FPCH_ACK);
         run({`FPCH_CMD_BLANK_CHECK, 8'h00}, 2); check(d, `FPCH_ACK);
         run({`FPCH_CMD_SECURITY, 8'h01}, 2); check(d, `FPCH_ACK);
         check(security_ff, 8'h01);
         run(`FPCH_CMD_CHIP_ERASE, 1); check(d, `FPCH_NAK);
         run({`FPCH_CMD_SECURITY, 8'h06}, 2); check(d, `FPCH_ACK);
         check(security_ff, 8'h07);
         run({`FPCH_CMD_BLOCK_ERASE, 8'h00}, 2); check(d, `FPCH_NAK);
         run({`FPCH_CMD_PROGRAM, 8'h02, 32'h00000000}, 6); check(d, `FPCH_NAK);
         run({`FPCH_CMD_BLANK_CHECK, 8'h02}, 2); check(d, `FPCH_ACK);
         $display("chip done");
      end
   endtask
   task t_normal;
      begin
         fpch_prog_model_inst.set_pins(1'b0, 1'b1);
         rst_n = 1'b0;
         repeat (4) @(negedge sys_clk);
         check({7'h00, mode_pulldown_ff}, 8'h01);
         check({7'h00, prog_mode_ff}, 8'h00);
         rst_n = 1'b1;
         repeat (4) @(negedge sys_clk);
         fpch_prog_model_inst.set_pins(1'b1, 1'b1);
         repeat (8) @(negedge sys_clk);
         check({7'h00, prog_mode_ff}, 8'h00);
         fpch_prog_model_inst.send(`FPCH_CMD_RESET);
         check({7'h00, tx_valid_ff}, 8'h00);
         $display("normal done");
      end
   endtask
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         errors = errors + 1;
         complete_run;
      end
   end
   initial begin
      t_entry;
      t_answers;
      t_flash;
      t_chip;
      t_normal;
      complete_run;
   end
endmodule // testbench

/* hdl/fpch_handler.v */
// Purpose: command interpreter serving an external flash programmer
// Assumes: command bytes arrive as valid-qualified bytes on sys_clk
// Notes: packet layout is cmd, block, then data bytes per command
`timescale 1ns/100ps
`include "fpch_defines.vh"

module fpch_handler #(
   parameter BLK_W = 2,
   parameter BLK_BYTES = 4,
   parameter ADR_W = 4
) (
   input wire sys_clk,
   input wire rst_n,
   input wire flash_mode_select_pin,
   input wire tool_serial_pin,
   input wire uart_mode,
   input wire rx_valid,
   input wire [7:0] rx_data,
   output reg prog_mode_ff,
   output reg mode_pulldown_ff,
   output reg tx_valid_ff,
   output reg [7:0] tx_data_ff,
   output reg [7:0] baud_ff,
   output reg [7:0] security_ff,
   output reg busy_ff
);

   localparam DEPTH = 1 << ADR_W;
   localparam OFS_W = ADR_W - BLK_W;
   localparam S_IDLE = 3'h0;
   localparam S_BLK = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_SCAN = 3'h3;
   localparam S_ANS = 3'h4;
   localparam S_ANS2 = 3'h5;

   // ------------------------------------------------------------
   // pin synchronisers and mode capture
   // ------------------------------------------------------------
   reg [1:0] fm_sync_ff;
   reg [1:0] tl_sync_ff;
   reg [1:0] settle_ff;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fm_sync_ff <= 2'h0;
         tl_sync_ff <= 2'h0;
         settle_ff <= 2'h0;
         prog_mode_ff <= 1'b0;
         mode_pulldown_ff <= 1'b1;
      end else begin
         fm_sync_ff <= {fm_sync_ff[0], flash_mode_select_pin};
         tl_sync_ff <= {tl_sync_ff[0], tool_serial_pin};
         mode_pulldown_ff <= 1'b0;
         if (settle_ff != `FPCH_SETTLE_END) begin
            settle_ff <= settle_ff + 2'h1;
         end
         // pins judged once, on the levels seen at reset release
         if (settle_ff == `FPCH_MODE_SAMPLE && fm_sync_ff[1] && tl_sync_ff[1]) begin
            prog_mode_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // flash array and command engine
   // ------------------------------------------------------------
   reg [7:0] mem_ff [0:DEPTH-1];
   reg [2:0] state_ff;
   reg [7:0] cmd_ff;
   reg [BLK_W-1:0] blk_ff;
   reg [OFS_W-1:0] ofs_ff;
   reg ok_ff;
   reg [7:0] sum_ff;
   reg [7:0] ans2_ff;
   integer i;

   wire [ADR_W-1:0] adr = {blk_ff, ofs_ff};
   wire last = (ofs_ff == (BLK_BYTES[OFS_W-1:0] - {{(OFS_W-1){1'b0}}, 1'b1}));
   wire known = (rx_data == `FPCH_CMD_RESET) || (rx_data == `FPCH_CMD_VERIFY) ||
      (rx_data == `FPCH_CMD_CHIP_ERASE) || (rx_data == `FPCH_CMD_BLOCK_ERASE) ||
      (rx_data == `FPCH_CMD_BLANK_CHECK) || (rx_data == `FPCH_CMD_PROGRAM) ||
      (rx_data == `FPCH_CMD_BAUD_SET) || (rx_data == `FPCH_CMD_SIGNATURE) ||
      (rx_data == `FPCH_CMD_VERSION) || (rx_data == `FPCH_CMD_CHECKSUM) ||
      (rx_data == `FPCH_CMD_SECURITY);

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         cmd_ff <= 8'h00;
         blk_ff <= {BLK_W{1'b0}};
         ofs_ff <= {OFS_W{1'b0}};
         ok_ff <= 1'b0;
         sum_ff <= 8'h00;
         ans2_ff <= 8'h00;
         tx_valid_ff <= 1'b0;
         tx_data_ff <= 8'h00;
         baud_ff <= `FPCH_BAUD_RST;
         security_ff <= `FPCH_SEC_RST;
         busy_ff <= 1'b0;
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_ff[i] <= `FPCH_ERASED;
         end
      end else begin
         tx_valid_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (rx_valid && prog_mode_ff) begin
                  cmd_ff <= rx_data;
                  ok_ff <= 1'b1;
                  sum_ff <= 8'h00;
                  ofs_ff <= {OFS_W{1'b0}};
                  if (!known) begin
                     tx_valid_ff <= 1'b1;
                     tx_data_ff <= `FPCH_NAK;
                  end else if (rx_data == `FPCH_CMD_RESET) begin
                     tx_valid_ff <= 1'b1;
                     tx_data_ff <= `FPCH_ACK;
                  end else if (rx_data == `FPCH_CMD_SIGNATURE) begin
                     ans2_ff <= `FPCH_SIG_BYTE;
                     state_ff <= S_ANS2;
                     tx_valid_ff <= 1'b1;
                     tx_data_ff <= `FPCH_ACK;
                  end else if (rx_data == `FPCH_CMD_VERSION) begin
                     ans2_ff <= `FPCH_VER_BYTE;
                     state_ff <= S_ANS2;
                     tx_valid_ff <= 1'b1;
                     tx_data_ff <= `FPCH_ACK;
                  end else if (rx_data == `FPCH_CMD_CHIP_ERASE) begin
                     if (security_ff[`FPCH_SEC_NO_CHIP_ERASE]) begin
                        tx_valid_ff <= 1'b1;
                        tx_data_ff <= `FPCH_NAK;
                     end else begin
                        busy_ff <= 1'b1;
                        blk_ff <= {BLK_W{1'b0}};
                        state_ff <= S_SCAN;
                     end
                  end else begin
                     state_ff <= S_BLK;
                  end
               end
            end
            S_BLK: begin
               if (rx_valid) begin
                  blk_ff <= rx_data[BLK_W-1:0];
                  case (cmd_ff)
                     `FPCH_CMD_BAUD_SET: begin
                        tx_valid_ff <= 1'b1;
                        state_ff <= S_IDLE;
                        if (uart_mode) begin
                           baud_ff <= rx_data;
                           tx_data_ff <= `FPCH_ACK;
                        end else begin
                           tx_data_ff <= `FPCH_NAK;
                        end
                     end
                     `FPCH_CMD_SECURITY: begin
                        security_ff <= security_ff | rx_data;
                        tx_valid_ff <= 1'b1;
                        tx_data_ff <= `FPCH_ACK;
                        state_ff <= S_IDLE;
                     end
                     `FPCH_CMD_BLOCK_ERASE: begin
                        if (security_ff[`FPCH_SEC_NO_BLOCK_ERASE]) begin
                           tx_valid_ff <= 1'b1;
                           tx_data_ff <= `FPCH_NAK;
                           state_ff <= S_IDLE;
                        end else begin
                           busy_ff <= 1'b1;
                           state_ff <= S_SCAN;
                        end
                     end
                     `FPCH_CMD_PROGRAM: begin
                        ok_ff <= !security_ff[`FPCH_SEC_NO_PROGRAM];
                        busy_ff <= 1'b1;
                        state_ff <= S_DATA;
                     end
                     `FPCH_CMD_VERIFY: state_ff <= S_DATA;
                     default: state_ff <= S_SCAN;
                  endcase
               end
            end
            S_DATA: begin
               if (rx_valid) begin
                  if (cmd_ff == `FPCH_CMD_PROGRAM && ok_ff) begin
                     mem_ff[adr] <= mem_ff[adr] & rx_data;
                  end
                  if (cmd_ff == `FPCH_CMD_VERIFY && mem_ff[adr] != rx_data) begin
                     ok_ff <= 1'b0;
                  end
                  ofs_ff <= ofs_ff + {{(OFS_W-1){1'b0}}, 1'b1};
                  if (last) begin
                     state_ff <= S_ANS;
                  end
               end
            end
            S_SCAN: begin
               if (cmd_ff != `FPCH_CMD_VERIFY) begin
                  if (cmd_ff == `FPCH_CMD_CHIP_ERASE || cmd_ff == `FPCH_CMD_BLOCK_ERASE) begin
                     mem_ff[adr] <= `FPCH_ERASED;
                  end
                  if (cmd_ff == `FPCH_CMD_BLANK_CHECK && mem_ff[adr] != `FPCH_ERASED) begin
                     ok_ff <= 1'b0;
                  end
                  sum_ff <= sum_ff + mem_ff[adr];
                  ofs_ff <= ofs_ff + {{(OFS_W-1){1'b0}}, 1'b1};
                  if (last) begin
                     if (cmd_ff == `FPCH_CMD_CHIP_ERASE &&
                         blk_ff != {BLK_W{1'b1}}) begin
                        blk_ff <= blk_ff + {{(BLK_W-1){1'b0}}, 1'b1};
                     end else begin
                        state_ff <= S_ANS;
                     end
                  end
               end
            end
            S_ANS: begin
               busy_ff <= 1'b0;
               tx_valid_ff <= 1'b1;
               state_ff <= S_IDLE;
               if (cmd_ff == `FPCH_CMD_CHECKSUM) begin
                  tx_data_ff <= `FPCH_ACK;
                  ans2_ff <= sum_ff;
                  state_ff <= S_ANS2;
               end else if (cmd_ff == `FPCH_CMD_BLANK_CHECK) begin
                  tx_data_ff <= ok_ff ? `FPCH_ACK : `FPCH_BLANK_NG;
               end else begin
                  tx_data_ff <= ok_ff ? `FPCH_ACK : `FPCH_NAK;
               end
            end
            S_ANS2: begin
               tx_valid_ff <= 1'b1;
               tx_data_ff <= ans2_ff;
               state_ff <= S_IDLE;
            end
            default: state_ff <= S_IDLE;
         endcase
         if (rx_valid && busy_ff && state_ff == S_SCAN) begin
            tx_valid_ff <= 1'b1;
            tx_data_ff <= `FPCH_NAK;
         end
      end
   end

endmodule // fpch_handler

/* pkg/fpch_defines.vh */
// Purpose: constants of the flash programming command handler
// Assumes: byte-wide command stream from a link receiver on sys_clk
// Notes: command codes and answer codes are local encodings
`ifndef FPCH_DEFINES_VH
`define FPCH_DEFINES_VH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define FPCH_CMD_RESET 8'h00
`define FPCH_CMD_VERIFY 8'h13
`define FPCH_CMD_CHIP_ERASE 8'h20
`define FPCH_CMD_BLOCK_ERASE 8'h22
`define FPCH_CMD_BLANK_CHECK 8'h32
`define FPCH_CMD_PROGRAM 8'h40
`define FPCH_CMD_BAUD_SET 8'h9A
`define FPCH_CMD_SIGNATURE 8'hC0
`define FPCH_CMD_VERSION 8'hC5
`define FPCH_CMD_CHECKSUM 8'hB0
`define FPCH_CMD_SECURITY 8'hA0

// ------------------------------------------------------------
// answer codes
// ------------------------------------------------------------
`define FPCH_ACK 8'h06
`define FPCH_NAK 8'h15
`define FPCH_BLANK_NG 8'h1B

// ------------------------------------------------------------
// flash array, security bits, reset values
// ------------------------------------------------------------
`define FPCH_ERASED 8'hFF
`define FPCH_SEC_NO_CHIP_ERASE 0
`define FPCH_SEC_NO_BLOCK_ERASE 1
`define FPCH_SEC_NO_PROGRAM 2
`define FPCH_SEC_RST 8'h00
`define FPCH_BAUD_RST 8'h00
`define FPCH_SIG_BYTE 8'h5A
`define FPCH_VER_BYTE 8'h01

// ------------------------------------------------------------
// mode pin sampling after reset release
// ------------------------------------------------------------
`define FPCH_MODE_SAMPLE 2'h2
`define FPCH_SETTLE_END 2'h3

`endif
